// File: rtl/hm_consts.svh
// register map, field positions, reset values and frame geometry for the time-slot mapper
//
// Behaviour
// [R1] enable bit three off disables transmit link three entirely; on lets it run.
// [R2] enable bit two switches every function of transmit link two off or on.
// [R3] transmit link one enable acts only in extended superframe or data-mode formats.
// [R4] receive enable bit three off disables receive link three entirely; on runs it.
// [R5] receive enable bit two switches every function of receive link two off or on.
// [R6] receive link one enable acts only in extended superframe or data-mode formats.
// [R7] transmit even select inserts link data in even frames; clear suppresses it.
// [R8] transmit odd select inserts link data in odd frames; clear suppresses it.
// [R9] transmit channel field picks one channel in binary, 0 is channel 1, 23 channel 24.
// [R10] channel field ignored whenever even and odd selects are both clear.
// [R11] each transmit bit mask flag set carries link data in that channel bit.
// [R12] bit mask flags have no effect while even and odd selects are both clear.
// [R13] mask flag 7 maps to the first, most significant channel bit, then downward.
// [R14] receive even select extracts link data from even frames; clear stops it.
// [R15] receive odd select extracts link data from odd frames; clear stops it.
// [R16] receive channel field picks one channel in binary, 0 is channel 1, 23 channel 24.
// [R17] transmit links two and three own separate, identical assignment and mask registers.
// [R18] receive links two and three own separate, identical assignment and mask registers.
// [R19] each receive bit mask flag set extracts that channel bit; clear skips it.
// [R20] even and odd both set means every frame carries the selected bits.
`ifndef HM_CONSTS_SVH
`define HM_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define HM_IDX_TX_EN 8'h84
`define HM_IDX_TX2_SLOT 8'h86
`define HM_IDX_TX3_SLOT 8'h87
`define HM_IDX_TX2_MASK 8'h89
`define HM_IDX_TX3_MASK 8'h8a
`define HM_IDX_RX_EN 8'h8b
`define HM_IDX_RX2_SLOT 8'h8d
`define HM_IDX_RX3_SLOT 8'h8e
`define HM_IDX_RX2_MASK 8'h90
`define HM_IDX_RX3_MASK 8'h91
`define HM_IDX_FORMAT 8'ha0
`define HM_IDX_STATUS 8'ha1

// field positions
`define HM_TX_EN_LSB 2
`define HM_RX_EN_LSB 0
`define HM_SLOT_EVEN_BIT 6
`define HM_SLOT_ODD_BIT 5
`define HM_FMT_ESF_BIT 0
`define HM_FMT_DATA_MODE_BIT 1

// reset values
`define HM_REG_RST 8'h00
`define HM_EN_RST 3'h0
`define HM_SLOT_RST 7'h00
`define HM_FMT_RST 2'h0

// frame geometry: 24 channels of 8 bits after the framing bit
`define HM_LAST_CH 5'h17
`define HM_LAST_BIT 3'h7

`endif

// File: rtl/hm_pkg.sv
// types shared by the time-slot mapper
`default_nettype none
package hm_pkg;

    // one channel assignment: frame parity selects and channel number
    typedef struct packed {
        logic even;
        logic odd;
        logic [4:0] channel_select;
    } hm_slot_type;

    // one bit time of a framed line stream, on sys_clk
    typedef struct packed {
        logic strobe;
        logic frame_start;
        logic frame_odd;
        logic dl_slot;
        logic data;
    } hm_line_type;

    // position of the current bit within the payload of a frame
    typedef struct packed {
        logic live;
        logic odd;
        logic [4:0] ch;
        logic [2:0] bit_no;
    } hm_pos_type;

endpackage
`default_nettype wire

// File: rtl/hm_timeslot_mapper.sv
// time-slot mapper: link enables, channel assignment and bit insertion/extraction
//
// Register access over Avalon-MM was chosen for this implementation.
`include "hm_consts.svh"
`default_nettype none

// ***********************************************
// frame position tracker, one per line direction
// ***********************************************
module hm_frame_pos (
    input wire logic sys_clk,
    input wire logic rst,
    input wire hm_pkg::hm_line_type line,
    output hm_pkg::hm_pos_type cur
);
    hm_pkg::hm_pos_type nxt;
    hm_pkg::hm_pos_type next_nxt;

    // the framing bit itself is no payload, so it never counts as live
    always_comb begin
        cur = nxt;
        if (line.frame_start) begin
            cur.live = 1'b0;
        end
    end

    // nxt holds the position the next strobe will land on
    always_comb begin
        next_nxt = nxt;
        if (line.strobe) begin
            if (line.frame_start) begin
                next_nxt.live = 1'b1;
                next_nxt.odd = line.frame_odd;
                next_nxt.ch = 5'h00;
                next_nxt.bit_no = 3'h0;
            end else if (nxt.live) begin
                next_nxt.bit_no = nxt.bit_no + 3'h1;
                if (nxt.bit_no == `HM_LAST_BIT) begin
                    next_nxt.ch = nxt.ch + 5'h01;
                    if (nxt.ch == `HM_LAST_CH) begin
                        next_nxt.live = 1'b0; // wait for next framing bit
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nxt <= '0;
        end else begin
            nxt <= next_nxt;
        end
    end
endmodule

// ***********************************************
// top: register file, insertion and extraction
// ***********************************************
module hm_timeslot_mapper (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire hm_pkg::hm_line_type tx_line,
    input wire logic [2:0] tx_link_data,
    output logic tx_line_out,
    output logic tx_line_valid,
    output logic [2:0] tx_link_req,
    output logic [2:0] tx_link_on,
    input wire hm_pkg::hm_line_type rx_line,
    output logic [2:0] rx_link_valid,
    output logic [2:0] rx_link_bit,
    output logic [2:0] rx_link_on
);
    logic [2:0] tx_en;
    logic [2:0] rx_en;
    logic [1:0] fmt;
    hm_pkg::hm_slot_type tx_slot [2];
    hm_pkg::hm_slot_type rx_slot [2];
    logic [7:0] tx_mask [2];
    logic [7:0] rx_mask [2];
    logic [2:0] next_tx_en;
    logic [2:0] next_rx_en;
    logic [1:0] next_fmt;
    hm_pkg::hm_slot_type next_tx_slot [2];
    hm_pkg::hm_slot_type next_rx_slot [2];
    logic [7:0] next_tx_mask [2];
    logic [7:0] next_rx_mask [2];
    logic [31:0] next_avs_readdata;
    logic next_avs_waitrequest;
    logic [7:0] idx;
    logic wr_take;
    logic fmt_ok;
    logic [2:0] tx_eff;
    logic [2:0] rx_eff;
    logic [2:0] tx_hit;
    logic [2:0] rx_hit;
    logic next_tx_line_out;
    logic next_tx_line_valid;
    logic [2:0] next_tx_link_req;
    logic [2:0] next_rx_link_valid;
    logic [2:0] next_rx_link_bit;
    hm_pkg::hm_pos_type tx_cur;
    hm_pkg::hm_pos_type rx_cur;

    // an assignment hits when its frame parity is selected, the channel
    // matches and the mask flag for that bit is set; flag 7 is the first bit
    function automatic logic slot_hit(
        input hm_pkg::hm_slot_type s,
        input logic [7:0] m,
        input hm_pkg::hm_pos_type p
    );
        logic par;
        par = p.odd ? s.odd : s.even; // [R7] [R8] [R14] [R15] [R20]
        slot_hit = p.live && par && (s.channel_select == p.ch) // [R9] [R16] [R10]
                   && m[3'h7 - p.bit_no]; // [R11] [R13] [R19] [R12]
    endfunction

    hm_frame_pos u_tx_pos (
        .sys_clk(sys_clk),
        .rst(rst),
        .line(tx_line),
        .cur(tx_cur)
    );

    hm_frame_pos u_rx_pos (
        .sys_clk(sys_clk),
        .rst(rst),
        .line(rx_line),
        .cur(rx_cur)
    );

    // ***********************************************
    // register file over the memory-mapped bus
    // ***********************************************

    assign idx = avs_address[9:2];
    assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];

    // writes land on the edge where waitrequest is seen low
    always_comb begin
        next_tx_en = tx_en;
        next_rx_en = rx_en;
        next_fmt = fmt;
        next_tx_slot = tx_slot;
        next_rx_slot = rx_slot;
        next_tx_mask = tx_mask;
        next_rx_mask = rx_mask;
        if (wr_take) begin
            case (idx)
                `HM_IDX_TX_EN: next_tx_en = avs_writedata[`HM_TX_EN_LSB +: 3];
                `HM_IDX_TX2_SLOT: next_tx_slot[0] = avs_writedata[6:0]; // [R17]
                `HM_IDX_TX3_SLOT: next_tx_slot[1] = avs_writedata[6:0]; // [R17]
                `HM_IDX_TX2_MASK: next_tx_mask[0] = avs_writedata[7:0];
                `HM_IDX_TX3_MASK: next_tx_mask[1] = avs_writedata[7:0];
                `HM_IDX_RX_EN: next_rx_en = avs_writedata[`HM_RX_EN_LSB +: 3];
                `HM_IDX_RX2_SLOT: next_rx_slot[0] = avs_writedata[6:0]; // [R18]
                `HM_IDX_RX3_SLOT: next_rx_slot[1] = avs_writedata[6:0]; // [R18]
                `HM_IDX_RX2_MASK: next_rx_mask[0] = avs_writedata[7:0];
                `HM_IDX_RX3_MASK: next_rx_mask[1] = avs_writedata[7:0];
                `HM_IDX_FORMAT: next_fmt = avs_writedata[1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_en <= `HM_EN_RST;
            rx_en <= `HM_EN_RST;
            fmt <= `HM_FMT_RST;
            for (int i = 0; i < 2; i++) begin
                tx_slot[i] <= `HM_SLOT_RST;
                rx_slot[i] <= `HM_SLOT_RST;
                tx_mask[i] <= `HM_REG_RST;
                rx_mask[i] <= `HM_REG_RST;
            end
        end else begin
            tx_en <= next_tx_en;
            rx_en <= next_rx_en;
            fmt <= next_fmt;
            tx_slot <= next_tx_slot;
            rx_slot <= next_rx_slot;
            tx_mask <= next_tx_mask;
            rx_mask <= next_rx_mask;
        end
    end

    // one wait cycle per access; read data is loaded while waitrequest is high
    always_comb begin
        next_avs_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
        next_avs_readdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            next_avs_readdata = 32'h0000_0000; // unmapped and reserved read zero
            case (idx)
                `HM_IDX_TX_EN: next_avs_readdata[`HM_TX_EN_LSB +: 3] = tx_en;
                `HM_IDX_TX2_SLOT: next_avs_readdata[6:0] = tx_slot[0];
                `HM_IDX_TX3_SLOT: next_avs_readdata[6:0] = tx_slot[1];
                `HM_IDX_TX2_MASK: next_avs_readdata[7:0] = tx_mask[0];
                `HM_IDX_TX3_MASK: next_avs_readdata[7:0] = tx_mask[1];
                `HM_IDX_RX_EN: next_avs_readdata[`HM_RX_EN_LSB +: 3] = rx_en;
                `HM_IDX_RX2_SLOT: next_avs_readdata[6:0] = rx_slot[0];
                `HM_IDX_RX3_SLOT: next_avs_readdata[6:0] = rx_slot[1];
                `HM_IDX_RX2_MASK: next_avs_readdata[7:0] = rx_mask[0];
                `HM_IDX_RX3_MASK: next_avs_readdata[7:0] = rx_mask[1];
                `HM_IDX_FORMAT: next_avs_readdata[1:0] = fmt;
                `HM_IDX_STATUS: next_avs_readdata[7:0] = {rx_cur.odd, tx_cur.odd,
                                                          rx_link_on, tx_link_on};
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= next_avs_waitrequest;
            avs_readdata <= next_avs_readdata;
        end
    end

    // ***********************************************
    // effective link enables
    // ***********************************************

    // link one rides the data link, which only exists in these two formats
    assign fmt_ok = fmt[`HM_FMT_ESF_BIT] || fmt[`HM_FMT_DATA_MODE_BIT];
    assign tx_eff = {tx_en[2], tx_en[1], tx_en[0] && fmt_ok}; // [R1] [R2] [R3]
    assign rx_eff = {rx_en[2], rx_en[1], rx_en[0] && fmt_ok}; // [R4] [R5] [R6]

    // ***********************************************
    // transmit insertion
    // ***********************************************

    // on a clash link one wins, then link two; the loser sees no request
    always_comb begin
        tx_hit[0] = tx_eff[0] && tx_line.strobe && tx_line.dl_slot; // [R3]
        for (int k = 0; k < 2; k++) begin
            tx_hit[k + 1] = tx_eff[k + 1] && tx_line.strobe
                            && slot_hit(tx_slot[k], tx_mask[k], tx_cur); // [R17]
        end
        next_tx_link_req[0] = tx_hit[0];
        next_tx_link_req[1] = tx_hit[1] && !tx_hit[0];
        next_tx_link_req[2] = tx_hit[2] && !tx_hit[1] && !tx_hit[0];
        next_tx_line_valid = tx_line.strobe;
        next_tx_line_out = tx_line_out;
        if (tx_line.strobe) begin
            next_tx_line_out = tx_line.data; // untouched bits pass through
            for (int k = 0; k < 3; k++) begin
                if (next_tx_link_req[k]) begin
                    next_tx_line_out = tx_link_data[k];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_line_out <= 1'b0;
            tx_line_valid <= 1'b0;
            tx_link_req <= 3'h0;
            tx_link_on <= 3'h0;
        end else begin
            tx_line_out <= next_tx_line_out;
            tx_line_valid <= next_tx_line_valid;
            tx_link_req <= next_tx_link_req;
            tx_link_on <= tx_eff; // engines idle while their bit is off
        end
    end

    // ***********************************************
    // receive extraction
    // ***********************************************

    // every link may tap the same bit; each holds its last bit between pulses
    always_comb begin
        rx_hit[0] = rx_eff[0] && rx_line.strobe && rx_line.dl_slot; // [R6]
        for (int k = 0; k < 2; k++) begin
            rx_hit[k + 1] = rx_eff[k + 1] && rx_line.strobe
                            && slot_hit(rx_slot[k], rx_mask[k], rx_cur); // [R18] [R19]
        end
        next_rx_link_valid = rx_hit;
        for (int k = 0; k < 3; k++) begin
            next_rx_link_bit[k] = rx_hit[k] ? rx_line.data : rx_link_bit[k];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_link_valid <= 3'h0;
            rx_link_bit <= 3'h0;
            rx_link_on <= 3'h0;
        end else begin
            rx_link_valid <= next_rx_link_valid;
            rx_link_bit <= next_rx_link_bit;
            rx_link_on <= rx_eff;
        end
    end

    // ***********************************************
    // assertions
    // ***********************************************

    property p_tx3_off; // [R1]
        @(posedge sys_clk) disable iff (rst)
        !tx_en[2] |=> !tx_link_req[2] && !tx_link_on[2];
    endproperty
    a_tx3_off: assert property (p_tx3_off) else $error("tx link three active while off");

    property p_tx2_off; // [R2]
        @(posedge sys_clk) disable iff (rst)
        !tx_en[1] |=> !tx_link_req[1] && !tx_link_on[1];
    endproperty
    a_tx2_off: assert property (p_tx2_off) else $error("tx link two active while off");

    property p_tx1_dl; // [R3]
        @(posedge sys_clk) disable iff (rst)
        tx_en[0] && fmt_ok && tx_line.strobe && tx_line.dl_slot
        |=> tx_link_req[0] && tx_line_out == $past(tx_link_data[0]) && tx_link_on[0];
    endproperty
    a_tx1_dl: assert property (p_tx1_dl) else $error("tx link one missed data link bit");

    property p_link1_fmt; // [R6]
        @(posedge sys_clk) disable iff (rst)
        !fmt_ok |=> !tx_link_on[0] && !rx_link_on[0] && !rx_link_valid[0];
    endproperty
    a_link1_fmt: assert property (p_link1_fmt) else $error("link one active in wrong format");

    property p_rx_off; // [R4]
        @(posedge sys_clk) disable iff (rst)
        !rx_en[2] && !rx_en[1] |=> rx_link_valid[2:1] == 2'h0 && rx_link_on[2:1] == 2'h0;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx link active while off");

    property p_tx2_insert; // [R9]
        @(posedge sys_clk) disable iff (rst)
        tx_en[1] && tx_line.strobe && tx_cur.live && !tx_hit[0]
        && (tx_cur.odd ? tx_slot[0].odd : tx_slot[0].even)
        && tx_slot[0].channel_select == tx_cur.ch && tx_mask[0][3'h7 - tx_cur.bit_no]
        |=> tx_link_req[1] && tx_line_out == $past(tx_link_data[1]) && tx_line_valid;
    endproperty
    a_tx2_insert: assert property (p_tx2_insert) else $error("tx link two bit not inserted");

    property p_tx_parity_block; // [R7]
        @(posedge sys_clk) disable iff (rst)
        tx_line.strobe && !(tx_cur.odd ? tx_slot[1].odd : tx_slot[1].even)
        |=> !tx_link_req[2];
    endproperty
    a_tx_parity_block: assert property (p_tx_parity_block) else $error("tx wrong parity");

    property p_tx_mask_skip; // [R11]
        @(posedge sys_clk) disable iff (rst)
        tx_line.strobe && tx_cur.live && !tx_mask[0][3'h7 - tx_cur.bit_no]
        |=> !tx_link_req[1];
    endproperty
    a_tx_mask_skip: assert property (p_tx_mask_skip) else $error("tx masked bit inserted");

    property p_rx_extract; // [R19]
        @(posedge sys_clk) disable iff (rst)
        rx_en[2] && rx_line.strobe && slot_hit(rx_slot[1], rx_mask[1], rx_cur)
        |=> rx_link_valid[2] && rx_link_bit[2] == $past(rx_line.data);
    endproperty
    a_rx_extract: assert property (p_rx_extract) else $error("rx link three bit not taken");

    property p_rx_none; // [R10]
        @(posedge sys_clk) disable iff (rst)
        !rx_slot[0].even && !rx_slot[0].odd |=> !rx_link_valid[1];
    endproperty
    a_rx_none: assert property (p_rx_none) else $error("rx link two taps with no parity");

    property p_bus_wait;
        @(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one wait");

    c_tx2_insert: cover property (@(posedge sys_clk) disable iff (rst) tx_link_req[1]);
    c_rx3_extract: cover property (@(posedge sys_clk) disable iff (rst) rx_link_valid[2]);
    c_tx1_dl: cover property (@(posedge sys_clk) disable iff (rst) tx_link_req[0]);
    c_bus_write: cover property (@(posedge sys_clk) disable iff (rst) wr_take);
endmodule
`default_nettype wire

// File: dv/hm_line_model.sv
// framed line stream model driving both directions of the mapper
`default_nettype none
// ************************************
// line stream source, one per bench
// ************************************
module hm_line_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic slow,
    output hm_pkg::hm_line_type tx_line,
    output hm_pkg::hm_line_type rx_line,
    output hm_pkg::hm_pos_type pos
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic par;
    logic [1:0] gap;
    hm_pkg::hm_line_type l;
    initial begin
        tx_line = '0;
        rx_line = '0;
        pos = '0;
    end
    // framing bit then 192 payload bits; data churns between strobes so stale bits never pass
    always @(posedge sys_clk) begin
        l = '0;
        l.data = 1'($urandom);
        if (rst || !run) begin
            cnt <= 8'h00;
            par <= 1'b1;
            gap <= 2'h0;
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else begin
            l.strobe = 1'b1;
            l.frame_start = (cnt == 8'h00);
            l.frame_odd = ~par;
            l.dl_slot = l.frame_start && ~par; // data link rides odd framing bits
            pos.live <= (cnt != 8'h00);
            pos.odd <= l.frame_start ? ~par : par;
            pos.ch <= 5'((cnt - 8'h01) >> 3);
            pos.bit_no <= 3'(cnt - 8'h01);
            cnt <= (cnt == 8'hc0) ? 8'h00 : cnt + 8'h01;
            if (cnt == 8'h00) begin
                par <= ~par;
            end
            gap <= slow ? 2'($urandom) : 2'h0;
        end
        tx_line <= l;
        l.data = 1'($urandom);
        rx_line <= l;
    end
endmodule
`default_nettype wire

// File: dv/test_hm_timeslot_mapper.sv
// self-checking bench for the time-slot mapper
`default_nettype none
module test_hm_timeslot_mapper;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, run, slow, avs_read, avs_write, avs_waitrequest;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [2:0] tx_link_data, tx_link_req, tx_link_on, rx_link_valid, rx_link_bit, rx_link_on;
    logic tx_line_out, tx_line_valid, pend, e_out, e_rb;
    logic [2:0] e_req, e_rv, t, r;
    hm_pkg::hm_line_type tx_line, rx_line;
    hm_pkg::hm_pos_type pos;
    logic [7:0] q, v;
    logic [7:0] sh [256];
    logic [7:0] idx [11] = '{8'h84, 8'h86, 8'h87, 8'h89, 8'h8a, 8'h8b, 8'h8d, 8'h8e,
        8'h90, 8'h91, 8'ha0};
    logic [7:0] msk [11] = '{8'h1c, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'h07, 8'h7f, 8'h7f,
        8'hff, 8'hff, 8'h03};
    int mismatches, num_checks, cycles;

    hm_line_model model (.sys_clk(sys_clk), .rst(rst), .run(run), .slow(slow),
        .tx_line(tx_line), .rx_line(rx_line), .pos(pos));
    hm_timeslot_mapper DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_line(tx_line), .tx_link_data(tx_link_data),
        .tx_line_out(tx_line_out), .tx_line_valid(tx_line_valid), .tx_link_req(tx_link_req),
        .tx_link_on(tx_link_on), .rx_line(rx_line), .rx_link_valid(rx_link_valid),
        .rx_link_bit(rx_link_bit), .rx_link_on(rx_link_on));

    // ************************************
    // helpers
    // ************************************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one bus access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] ix, input logic [7:0] d,
        input logic be, output logic [7:0] rd);
        int n;
        @(posedge sys_clk);
        avs_address <= {ix, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= {3'b000, be};
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) mismatches++;
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    function automatic logic hit(input logic [7:0] s, input logic [7:0] m, input logic on,
        input hm_pkg::hm_pos_type p);
        return on && p.live && ((s[6] && !p.odd) || (s[5] && p.odd)) && s[4:0] === p.ch
            && m[3'h7 - p.bit_no];
    endfunction

    // effective enables; link one needs a format that carries a data link
    function automatic logic [2:0] ton();
        return {sh[8'h84][4:3], sh[8'h84][2] & |sh[8'ha0][1:0]};
    endfunction
    function automatic logic [2:0] ron();
        return {sh[8'h8b][2:1], sh[8'h8b][0] & |sh[8'ha0][1:0]};
    endfunction

    // ************************************
    // stream monitor: checks every cycle against the bit sampled one edge before
    // ************************************
    always @(posedge sys_clk) begin
        cycles++;
        tx_link_data <= 3'($urandom);
        if (cycles > 60000) begin
            mismatches++;
            test_done();
        end
        if (!rst) begin
            check({tx_line_valid, tx_link_req}, {pend, e_req});
            check(rx_link_valid, e_rv);
            if (pend) check(tx_line_out, e_out);
            if (pend) check(rx_link_bit & e_rv, {3{e_rb}} & e_rv);
        end
        pend = tx_line.strobe;
        t = ton();
        r = ron();
        e_req[0] = t[0] && tx_line.dl_slot;
        e_req[1] = hit(sh[8'h86], sh[8'h89], t[1], pos) && !e_req[0];
        e_req[2] = hit(sh[8'h87], sh[8'h8a], t[2], pos) && !e_req[0] && !e_req[1];
        e_out = e_req[0] ? tx_link_data[0] : e_req[1] ? tx_link_data[1]
            : e_req[2] ? tx_link_data[2] : tx_line.data;
        e_rv = {hit(sh[8'h8e], sh[8'h91], r[2], pos), hit(sh[8'h8d], sh[8'h90], r[1], pos),
            r[0] && rx_line.dl_slot};
        e_rb = rx_line.data;
        if (!pend) begin
            e_req = 3'h0;
            e_rv = 3'h0;
        end
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        rst = 1'b1;
        run = 1'b0;
        slow = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        tx_link_data = 3'h0;
        pend = 1'b0;
        foreach (sh[i]) sh[i] = 8'h00;
        v = 8'($urandom(32'h8aa2));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 11; k++) begin
            bus(1'b0, idx[k], 8'h00, 1'b1, q);
            check(q, 32'h0);
        end
        // unmapped slot and a write without its byte lane must leave nothing behind
        bus(1'b1, 8'h85, 8'hff, 1'b1, q);
        bus(1'b0, 8'h85, 8'h00, 1'b1, q);
        check(q, 32'h0);
        bus(1'b1, 8'h89, 8'h5a, 1'b0, q);
        bus(1'b0, 8'h89, 8'h00, 1'b1, q);
        check(q, 32'h0);
        // first passes are corner cases: selects both clear, last channel, first channel
        for (int it = 0; it < 16; it++) begin
            for (int k = 0; k < 11; k++) begin
                v = 8'($urandom);
                if (it < 3 && (k == 0 || k == 5)) v = 8'hff;
                if (it < 3 && k == 10) v = 8'h01;
                if (k inside {1, 2, 6, 7} && it < 3) begin
                    v = it == 0 ? 8'h17 : it == 1 ? (k[0] ? 8'h57 : 8'h37) : 8'h60;
                end
                bus(1'b1, idx[k], v, 1'b1, q);
                sh[idx[k]] = v & msk[k];
            end
            for (int k = 0; k < 11; k++) begin
                bus(1'b0, idx[k], 8'h00, 1'b1, q);
                check(q & msk[k], sh[idx[k]]);
            end
            bus(1'b0, 8'ha1, 8'h00, 1'b1, q);
            check(q[5:0], {ron(), ton()});
            check({rx_link_on, tx_link_on}, {ron(), ton()});
            slow <= 1'(it);
            run <= 1'b1;
            repeat (1600) @(posedge sys_clk);
            run <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        test_done();
    end
endmodule
`default_nettype wire
